// ===== hw/ocf_top.sv
`timescale 1ns/1ps
`include "ocf_params.svh"
module ocf_top
  import ocf_pkg::*;
#(
  parameter int PADDR_W = `OCF_PADDR_W,
  parameter int BASE_WRAP = `OCF_BASE_WRAP,
  parameter int FP_1HZ_TICKS = `OCF_FP_1HZ_TICKS
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [PADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic transmit_path_loop_tick,
  input logic receive_path_loop_tick,
  output logic apll_ref_tick,
  output logic synth_ref_tick,
  output logic [19:0] se_freq_khz,
  output logic se_code_valid,
  output logic [19:0] diff_freq_khz,
  output logic diff_code_valid,
  output logic [31:0] synth_freq_hz,
  output logic synth_over_range,
  output logic frame_pulse_output,
  output logic frame_start
);
  localparam int IDX_W = PADDR_W - 2;
  localparam int FP64_MIN = BASE_WRAP / 2;
  localparam int FP64_MAX = (BASE_WRAP + 1) / 2;
  localparam logic [15:0] N_BASE =
    16'(`OCF_CLK_HZ / `OCF_SYNTH_STEP_HZ);
  localparam logic [15:0] N_MAX =
    16'(`OCF_SYNTH_MAX_HZ / `OCF_SYNTH_STEP_HZ);

  logic [7:0] cfg_reg [`OCF_NUM_REGS];
  logic [31:0] prdata_reg;
  logic [2:0] slot;
  logic mapped;

  function automatic logic [20:0] se_lookup(input logic eth,
                                            input logic [3:0] code);
    logic [20:0] r;
    r = '0;
    if (!eth) begin
      case (code)
        4'h2: r = {1'b1, `OCF_F77760};
        4'h3: r = {1'b1, `OCF_F38880};
        4'h4: r = {1'b1, `OCF_F19440};
        4'h5: r = {1'b1, `OCF_F9720};
        4'hA: r = {1'b1, `OCF_F51840};
        4'hB: r = {1'b1, `OCF_F25920};
        4'hC: r = {1'b1, `OCF_F12960};
        4'hD: r = {1'b1, `OCF_F6480};
        default: r = '0;
      endcase
    end else begin
      case (code)
        4'h1: r = {1'b1, `OCF_F125000};
        4'h2: r = {1'b1, `OCF_F62500};
        4'h5: r = {1'b1, `OCF_F50000};
        4'h6: r = {1'b1, `OCF_F25000};
        4'h7: r = {1'b1, `OCF_F12500};
        default: r = '0;
      endcase
    end
    return r;
  endfunction : se_lookup

  function automatic logic [20:0] diff_lookup(input ocf_family_t fam,
                                              input logic [2:0] code);
    logic [20:0] r;
    r = '0;
    case (fam)
      ocf_sonet: begin
        case (code)
          3'h0: r = {1'b1, `OCF_F19440};
          3'h1: r = {1'b1, `OCF_F38880};
          3'h2: r = {1'b1, `OCF_F77760};
          3'h3: r = {1'b1, `OCF_F155520};
          3'h4: r = {1'b1, `OCF_F311040};
          3'h5: r = {1'b1, `OCF_F622080};
          3'h6: r = {1'b1, `OCF_F6480};
          default: r = {1'b1, `OCF_F51840};
        endcase
      end
      ocf_eth_low: begin
        case (code)
          3'h1: r = {1'b1, `OCF_F125000};
          3'h2: r = {1'b1, `OCF_F62500};
          3'h5: r = {1'b1, `OCF_F50000};
          3'h6: r = {1'b1, `OCF_F25000};
          3'h7: r = {1'b1, `OCF_F12500};
          default: r = '0;
        endcase
      end
      default: begin
        case (code)
          3'h3: r = {1'b1, `OCF_F156250};
          3'h4: r = {1'b1, `OCF_F312500};
          default: r = '0;
        endcase
      end
    endcase
    return r;
  endfunction : diff_lookup

  // Frame period in base ticks of 64 kHz; zero stops the frame pulse.
  function automatic logic [15:0] fp_period(input logic [3:0] code);
    logic [15:0] r;
    r = '0;
    case (code)
      4'h0: r = `OCF_FP_T_166;
      4'h1: r = `OCF_FP_T_400;
      4'h2: r = `OCF_FP_T_1K;
      4'h3: r = `OCF_FP_T_2K;
      4'h4: r = `OCF_FP_T_4K;
      4'h5: r = `OCF_FP_T_8K;
      4'h6: r = `OCF_FP_T_32K;
      4'h7: r = `OCF_FP_T_64K;
      4'h8: r = 16'(FP_1HZ_TICKS);
      default: r = '0;
    endcase
    return r;
  endfunction : fp_period

  function automatic logic [15:0] hz_to_cycles(input int hz);
    int c;
    c = `OCF_CLK_HZ / hz;
    if (c < 1) begin
      c = 1;
    end
    return 16'(c);
  endfunction : hz_to_cycles

  wire [IDX_W-1:0] reg_idx = paddr[PADDR_W-1:2];
  wire aligned = paddr[1:0] == 2'h0;
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire wr_en = access_ph && pwrite && mapped && pstrb[0];

  always_comb begin
    slot = `OCF_SLOT_SYNTH_EN;
    mapped = aligned;
    if (reg_idx == IDX_W'(`OCF_IDX_SYNTH_EN)) begin
      slot = `OCF_SLOT_SYNTH_EN;
    end else if (reg_idx == IDX_W'(`OCF_IDX_MULT_LO)) begin
      slot = `OCF_SLOT_MULT_LO;
    end else if (reg_idx == IDX_W'(`OCF_IDX_MULT_HI)) begin
      slot = `OCF_SLOT_MULT_HI;
    end else if (reg_idx == IDX_W'(`OCF_IDX_FP_RATE)) begin
      slot = `OCF_SLOT_FP_RATE;
    end else if (reg_idx == IDX_W'(`OCF_IDX_FP_SHAPE)) begin
      slot = `OCF_SLOT_FP_SHAPE;
    end else if (reg_idx == IDX_W'(`OCF_IDX_FAMILY)) begin
      slot = `OCF_SLOT_FAMILY;
    end else if (reg_idx == IDX_W'(`OCF_IDX_SE_RATE)) begin
      slot = `OCF_SLOT_SE_RATE;
    end else if (reg_idx == IDX_W'(`OCF_IDX_DIFF_RATE)) begin
      slot = `OCF_SLOT_DIFF_RATE;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `OCF_NUM_REGS; i++) begin
        cfg_reg[i] <= `OCF_RST_BYTE;
      end
    end else if (wr_en) begin
      cfg_reg[slot] <= pwdata[7:0];
    end
  end

  // Read data is captured in the setup cycle so it is a flop output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup_ph) begin
      prdata_reg <= mapped ? {24'h000000, cfg_reg[slot]} : '0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;

  wire [7:0] synth_enable_source = cfg_reg[`OCF_SLOT_SYNTH_EN];
  wire [7:0] synth_multiplier_low = cfg_reg[`OCF_SLOT_MULT_LO];
  wire [7:0] synth_multiplier_high = cfg_reg[`OCF_SLOT_MULT_HI];
  wire [7:0] frame_pulse_rate = cfg_reg[`OCF_SLOT_FP_RATE];
  wire [7:0] frame_pulse_shape = cfg_reg[`OCF_SLOT_FP_SHAPE];
  wire [7:0] pll_family_select = cfg_reg[`OCF_SLOT_FAMILY];
  wire [7:0] single_ended_rate = cfg_reg[`OCF_SLOT_SE_RATE];
  wire [7:0] differential_rate = cfg_reg[`OCF_SLOT_DIFF_RATE];

  wire src_rx = synth_enable_source[`OCF_B_SRC_RX];
  wire eth_en = pll_family_select[`OCF_B_ETH_EN];
  wire se_low = pll_family_select[`OCF_B_SE_LOW];
  wire diff_low = pll_family_select[`OCF_B_DIFF_LOW];
  wire se_eth = eth_en && se_low;
  wire [3:0] se_code = single_ended_rate[`OCF_F_SE_CODE];
  wire [2:0] diff_code = differential_rate[`OCF_F_DIFF_CODE];
  wire ocf_family_t diff_fam = !eth_en ? ocf_sonet :
    (diff_low ? ocf_eth_low : ocf_eth_high);
  wire [20:0] se_entry = se_lookup(se_eth, se_code);
  wire [20:0] diff_entry = diff_lookup(diff_fam, diff_code);
  wire [15:0] mult_n = {synth_multiplier_high, synth_multiplier_low};
  wire [31:0] synth_hz_w = (mult_n == '0) ? 32'(`OCF_SYNTH_ZERO_HZ) :
    32'(mult_n) * 32'(`OCF_SYNTH_STEP_HZ);
  wire [15:0] pclk_div = (mult_n == '0) ?
    hz_to_cycles(`OCF_SYNTH_ZERO_HZ) : N_BASE / mult_n;
  wire [15:0] pclk_cycles = (pclk_div == '0) ? 16'h0001 : pclk_div;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se_freq_khz <= '0;
      se_code_valid <= 1'b0;
      diff_freq_khz <= '0;
      diff_code_valid <= 1'b0;
      synth_freq_hz <= '0;
      synth_over_range <= 1'b0;
    end else begin
      {se_code_valid, se_freq_khz} <= se_entry;
      {diff_code_valid, diff_freq_khz} <= diff_entry;
      synth_freq_hz <= synth_hz_w;
      synth_over_range <= mult_n > N_MAX;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apll_ref_tick <= 1'b0;
      synth_ref_tick <= 1'b0;
    end else begin
      apll_ref_tick <= transmit_path_loop_tick;
      synth_ref_tick <= src_rx ? receive_path_loop_tick :
        transmit_path_loop_tick;
    end
  end

  // Base tick of 64 kHz on average, counted in half clock cycles.
  logic [12:0] base_acc_reg;
  wire [12:0] base_sum = base_acc_reg + `OCF_BASE_STEP;
  wire base_tick = base_sum >= 13'(BASE_WRAP);
  wire base_half = base_acc_reg >= 13'(BASE_WRAP / 2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_acc_reg <= '0;
    end else begin
      base_acc_reg <= base_tick ? base_sum - 13'(BASE_WRAP) : base_sum;
    end
  end

  wire [2:0] fpw_code = frame_pulse_shape[`OCF_F_FP_WIDTH];
  logic [15:0] width_cycles;
  always_comb begin
    case (fpw_code)
      3'h0: width_cycles = hz_to_cycles(`OCF_FPW_HZ_0);
      3'h1: width_cycles = hz_to_cycles(`OCF_FPW_HZ_1);
      3'h2: width_cycles = hz_to_cycles(`OCF_FPW_HZ_2);
      3'h3: width_cycles = hz_to_cycles(`OCF_FPW_HZ_3);
      3'h4: width_cycles = hz_to_cycles(`OCF_FPW_HZ_4);
      default: width_cycles = pclk_cycles;
    endcase
  end

  // Falling-edge alignment starts the pulse half a synthesized period late; clock style ignores it.
  wire fp_fall = frame_pulse_shape[`OCF_B_FP_FALL];
  wire [15:0] delay_cycles = fp_fall ? (pclk_cycles >> 1) : '0;
  wire [15:0] period_ticks = fp_period(frame_pulse_rate[`OCF_F_FP_RATE]);

  ocf_frame_pulse u_frame_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .base_tick(base_tick),
    .base_half(base_half),
    .period_ticks(period_ticks),
    .width_cycles(width_cycles),
    .delay_cycles(delay_cycles),
    .clock_style(frame_pulse_shape[`OCF_B_FP_CLOCK]),
    .invert(frame_pulse_shape[`OCF_B_FP_NEG]),
    .frame_pulse_output(frame_pulse_output),
    .frame_start(frame_start)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apll_tx_only: assert property (
    $past(transmit_path_loop_tick) == apll_ref_tick)
    else $error("analog PLL reference not the transmit loop");
  a_synth_src_mux: assert property (
    ($stable(src_rx) && src_rx)
    |-> synth_ref_tick == $past(receive_path_loop_tick))
    else $error("synthesizer reference not the receive loop");
  a_se_sonet_code: assert property (
    (!se_eth && se_code == 4'hD)
    |=> se_freq_khz == `OCF_F6480 && se_code_valid)
    else $error("single-ended SONET code 1101 not 6.48 MHz");
  a_se_eth_code: assert property (
    (se_eth && se_code == 4'h1) |=> se_freq_khz == `OCF_F125000)
    else $error("single-ended Ethernet code 0001 not 125 MHz");
  a_se_eth_resv: assert property (
    (se_eth && se_code == 4'h3) |=> !se_code_valid)
    else $error("reserved Ethernet single-ended code marked valid");
  a_diff_sonet_map: assert property (
    (!eth_en && diff_code == 3'h5) |=> diff_freq_khz == `OCF_F622080)
    else $error("differential SONET code 101 not 622.08 MHz");
  a_diff_low_map: assert property (
    (eth_en && diff_low && !se_low && diff_code == 3'h6)
    |=> diff_freq_khz == `OCF_F25000 && diff_code_valid)
    else $error("differential low-speed code 110 not 25 MHz");
  a_diff_high_map: assert property (
    (eth_en && !diff_low && diff_code == 3'h4)
    |=> diff_freq_khz == `OCF_F312500 && diff_code_valid)
    else $error("differential high-speed code 100 not 312.5 MHz");
  a_synth_n_freq: assert property (
    (mult_n != '0)
    |=> synth_freq_hz == $past(mult_n) * `OCF_SYNTH_STEP_HZ)
    else $error("synthesizer frequency not N times 8 kHz");
  a_synth_zero_n: assert property (
    (mult_n == '0) |=> synth_freq_hz == `OCF_SYNTH_ZERO_HZ)
    else $error("zero multiplier not 2 kHz");
  // Frame spacing can exceed a delay range, so it is counted in cycles.
  logic [15:0] fs_gap_reg;
  logic fs_rate64_reg;
  wire rate64 = frame_pulse_rate[`OCF_F_FP_RATE] == 4'h7;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_gap_reg <= '0;
      fs_rate64_reg <= 1'b0;
    end else if (frame_start) begin
      fs_gap_reg <= 16'h0001;
      fs_rate64_reg <= rate64;
    end else if (fs_gap_reg != 16'hFFFF) begin
      fs_gap_reg <= fs_gap_reg + 16'h0001;
    end
  end

  a_fp_rate_64k: assert property (
    (frame_start && rate64 && fs_rate64_reg)
    |-> fs_gap_reg >= FP64_MIN && fs_gap_reg <= FP64_MAX)
    else $error("64 kHz frame spacing wrong");

  c_se_ethernet: cover property (se_eth && se_code_valid);
  c_diff_high: cover property (diff_fam == ocf_eth_high && diff_code_valid);
  c_fp_falling: cover property (fp_fall && $rose(frame_pulse_output));
  c_synth_zero: cover property (mult_n == '0 && synth_ref_tick);
endmodule : ocf_top

// ===== pkg/ocf_params.svh
`ifndef OCF_PARAMS_SVH
`define OCF_PARAMS_SVH
`define OCF_PADDR_W 12
`define OCF_IDX_SYNTH_EN 8'h36
`define OCF_IDX_MULT_LO 8'h38
`define OCF_IDX_MULT_HI 8'h39
`define OCF_IDX_FP_RATE 8'h3E
`define OCF_IDX_FP_SHAPE 8'h3F
`define OCF_IDX_FAMILY 8'h51
`define OCF_IDX_SE_RATE 8'h52
`define OCF_IDX_DIFF_RATE 8'h61
`define OCF_NUM_REGS 8
`define OCF_SLOT_SYNTH_EN 3'h0
`define OCF_SLOT_MULT_LO 3'h1
`define OCF_SLOT_MULT_HI 3'h2
`define OCF_SLOT_FP_RATE 3'h3
`define OCF_SLOT_FP_SHAPE 3'h4
`define OCF_SLOT_FAMILY 3'h5
`define OCF_SLOT_SE_RATE 3'h6
`define OCF_SLOT_DIFF_RATE 3'h7
`define OCF_RST_BYTE 8'h00
`define OCF_B_SRC_RX 0
`define OCF_B_ETH_EN 0
`define OCF_B_SE_LOW 1
`define OCF_B_DIFF_LOW 2
`define OCF_F_SE_CODE 3:0
`define OCF_F_DIFF_CODE 2:0
`define OCF_F_FP_RATE 3:0
`define OCF_F_FP_WIDTH 2:0
`define OCF_B_FP_CLOCK 3
`define OCF_B_FP_FALL 4
`define OCF_B_FP_NEG 5
`define OCF_CLK_HZ 100000000
`define OCF_PERIOD_PS 10000
`define OCF_BASE_PERIOD_PS 15625000
`define OCF_BASE_WRAP ((2 * `OCF_BASE_PERIOD_PS) / `OCF_PERIOD_PS)
`define OCF_BASE_STEP 13'h0002
`define OCF_FP_1HZ_TICKS 64000
`define OCF_FP_T_166 16'h0180
`define OCF_FP_T_400 16'h00A0
`define OCF_FP_T_1K 16'h0040
`define OCF_FP_T_2K 16'h0020
`define OCF_FP_T_4K 16'h0010
`define OCF_FP_T_8K 16'h0008
`define OCF_FP_T_32K 16'h0002
`define OCF_FP_T_64K 16'h0001
`define OCF_FPW_HZ_0 4096000
`define OCF_FPW_HZ_1 8192000
`define OCF_FPW_HZ_2 16384000
`define OCF_FPW_HZ_3 32768000
`define OCF_FPW_HZ_4 65536000
`define OCF_SYNTH_STEP_HZ 8000
`define OCF_SYNTH_ZERO_HZ 2000
`define OCF_SYNTH_MAX_HZ 100000000
`define OCF_F6480 20'h01950
`define OCF_F9720 20'h025F8
`define OCF_F12500 20'h030D4
`define OCF_F12960 20'h032A0
`define OCF_F19440 20'h04BF0
`define OCF_F25000 20'h061A8
`define OCF_F25920 20'h06540
`define OCF_F38880 20'h097E0
`define OCF_F50000 20'h0C350
`define OCF_F51840 20'h0CA80
`define OCF_F62500 20'h0F424
`define OCF_F77760 20'h12FC0
`define OCF_F125000 20'h1E848
`define OCF_F155520 20'h25F80
`define OCF_F156250 20'h2625A
`define OCF_F311040 20'h4BF00
`define OCF_F312500 20'h4C4B4
`define OCF_F622080 20'h97E00
`endif

// ===== pkg/ocf_pkg.sv
package ocf_pkg;
  typedef enum logic [1:0] {
    ocf_sonet,
    ocf_eth_low,
    ocf_eth_high
  } ocf_family_t;
  typedef enum logic [1:0] {
    fp_idle,
    fp_delay,
    fp_pulse
  } ocf_fp_state_t;
endpackage : ocf_pkg

// ===== hw/ocf_frame_pulse.sv
`timescale 1ns/1ps
`include "ocf_params.svh"
module ocf_frame_pulse
  import ocf_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic base_tick,
  input logic base_half,
  input logic [15:0] period_ticks,
  input logic [15:0] width_cycles,
  input logic [15:0] delay_cycles,
  input logic clock_style,
  input logic invert,
  output logic frame_pulse_output,
  output logic frame_start
);
  ocf_fp_state_t state_reg, state_next;
  logic [15:0] frame_cnt_reg;
  logic [15:0] cnt_reg, cnt_next;
  logic frame_pulse_reg;
  logic frame_start_reg;
  wire running = period_ticks != '0;
  wire wrap = base_tick && running && frame_cnt_reg >= period_ticks - 16'h0001;
  wire [16:0] half_pos = {frame_cnt_reg, base_half};
  wire clk_level = half_pos < {1'b0, period_ticks};
  wire pulse_level = clock_style ? clk_level : state_reg == fp_pulse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_reg <= '0;
    end else if (!running) begin
      frame_cnt_reg <= '0;
    end else if (base_tick) begin
      frame_cnt_reg <= wrap ? '0 : frame_cnt_reg + 16'h0001;
    end
  end

  // A new frame restarts the pulse even if the previous one is running.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      fp_delay: begin
        cnt_next = cnt_reg - 16'h0001;
        if (cnt_reg <= 16'h0001) begin
          state_next = fp_pulse;
          cnt_next = width_cycles;
        end
      end
      fp_pulse: begin
        cnt_next = cnt_reg - 16'h0001;
        if (cnt_reg <= 16'h0001) begin
          state_next = fp_idle;
        end
      end
      default: begin
        state_next = fp_idle;
      end
    endcase
    if (wrap && !clock_style) begin
      if (delay_cycles != '0) begin
        state_next = fp_delay;
        cnt_next = delay_cycles;
      end else begin
        state_next = fp_pulse;
        cnt_next = width_cycles;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= fp_idle;
      cnt_reg <= '0;
      frame_pulse_reg <= 1'b0;
      frame_start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      frame_pulse_reg <= pulse_level ^ invert;
      frame_start_reg <= wrap;
    end
  end

  assign frame_pulse_output = frame_pulse_reg;
  assign frame_start = frame_start_reg;

  property p_width3;
    @(posedge pclk) disable iff (!presetn)
      (!clock_style && $stable(width_cycles) && width_cycles == 16'h0003
       && delay_cycles == '0 && $rose(state_reg == fp_pulse))
      |-> (state_reg == fp_pulse) [*3] ##1 (state_reg != fp_pulse || wrap);
  endproperty
  a_fp_width_count: assert property (p_width3)
    else $error("frame pulse width not three cycles");

  a_fp_idle_level: assert property (
    @(posedge pclk) disable iff (!presetn)
      (!clock_style && state_reg == fp_idle && $stable(invert))
      |=> frame_pulse_output == $past(invert))
    else $error("idle frame pulse level wrong for polarity");
endmodule : ocf_frame_pulse

// ===== verif/ocf_loop_model.sv
`timescale 1ns/1ps
module ocf_loop_model #(
  parameter int TX_DIV = 3,
  parameter int RX_DIV = 5
) (
  input logic pclk,
  input logic presetn,
  output logic transmit_path_loop_tick,
  output logic receive_path_loop_tick
);
  // The two loops tick at coprime rates so a wrong source pick shows at once.
  int tx_cnt_reg;
  int rx_cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_reg <= 0;
      rx_cnt_reg <= 0;
      transmit_path_loop_tick <= 1'b0;
      receive_path_loop_tick <= 1'b0;
    end else begin
      tx_cnt_reg <= (tx_cnt_reg == TX_DIV - 1) ? 0 : tx_cnt_reg + 1;
      rx_cnt_reg <= (rx_cnt_reg == RX_DIV - 1) ? 0 : rx_cnt_reg + 1;
      transmit_path_loop_tick <= (tx_cnt_reg == TX_DIV - 1);
      receive_path_loop_tick <= (rx_cnt_reg == RX_DIV - 1);
    end
  end
endmodule : ocf_loop_model

// ===== verif/ocf_top_tb.sv
`timescale 1ns/1ps
`include "ocf_params.svh"
module ocf_top_tb;
  localparam int BW = 20;
  localparam int F1 = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, syn_f;
  logic [3:0] pstrb;
  logic tx_t, rx_t, apll_t, syn_t, se_v, df_v, ovr, fpo, fst, a, b;
  logic [19:0] se_f, df_f;
  int err_total, n_checks, cyc, p, w;
  logic [7:0] ix [8] = '{`OCF_IDX_SYNTH_EN, `OCF_IDX_MULT_LO,
    `OCF_IDX_MULT_HI, `OCF_IDX_FP_RATE, `OCF_IDX_FP_SHAPE,
    `OCF_IDX_FAMILY, `OCF_IDX_SE_RATE, `OCF_IDX_DIFF_RATE};
  logic [15:0] tk [9] = '{`OCF_FP_T_166, `OCF_FP_T_400, `OCF_FP_T_1K,
    `OCF_FP_T_2K, `OCF_FP_T_4K, `OCF_FP_T_8K, `OCF_FP_T_32K,
    `OCF_FP_T_64K, 16'h0004};
  logic [7:0] shp [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h27,
    8'h08, 8'h17};
  int wexp [9] = '{24, 12, 6, 3, 1, 50, 50, 40, 50};
  // E1 multiple for the fixed widths, a plain 2 MHz clock for code 111.
  logic [15:0] nv [9] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100,
    16'h0100, 16'h00FA, 16'h00FA, 16'h00FA, 16'h00FA};
  logic [15:0] nt [5] = '{16'h0000, 16'h0001, 16'h30D4, 16'h30D5, 16'hFFFF};

  ocf_top #(.BASE_WRAP(BW), .FP_1HZ_TICKS(F1)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .transmit_path_loop_tick(tx_t),
    .receive_path_loop_tick(rx_t), .apll_ref_tick(apll_t),
    .synth_ref_tick(syn_t), .se_freq_khz(se_f), .se_code_valid(se_v),
    .diff_freq_khz(df_f), .diff_code_valid(df_v), .synth_freq_hz(syn_f),
    .synth_over_range(ovr), .frame_pulse_output(fpo), .frame_start(fst));
  ocf_loop_model lm (.pclk(pclk), .presetn(presetn),
    .transmit_path_loop_tick(tx_t), .receive_path_loop_tick(rx_t));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [32:0] s,
      input logic [32:0] x);
    n_checks++;
    if (s !== x) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic bus(input logic wn, input logic [7:0] i, input logic [7:0] d,
      input logic [3:0] s);
    int g;
    g = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wn;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'hA5A5A5, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      g++;
    end while (pready !== 1'b1 && g < 50);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 4'hF);
    repeat (2) @(negedge pclk);
  endtask : wr

  task automatic wait_start();
    int g;
    g = 0;
    do begin
      @(negedge pclk);
      g++;
    end while (fst !== 1'b1 && g < 5000);
  endtask : wait_start

  function automatic logic [20:0] se_x(input logic [4:0] k);
    case (k)
      5'h02: return {1'b1, `OCF_F77760};
      5'h03: return {1'b1, `OCF_F38880};
      5'h04: return {1'b1, `OCF_F19440};
      5'h05: return {1'b1, `OCF_F9720};
      5'h0A: return {1'b1, `OCF_F51840};
      5'h0B: return {1'b1, `OCF_F25920};
      5'h0C: return {1'b1, `OCF_F12960};
      5'h0D: return {1'b1, `OCF_F6480};
      5'h11: return {1'b1, `OCF_F125000};
      5'h12: return {1'b1, `OCF_F62500};
      5'h15: return {1'b1, `OCF_F50000};
      5'h16: return {1'b1, `OCF_F25000};
      5'h17: return {1'b1, `OCF_F12500};
      default: return 21'h000000;
    endcase
  endfunction : se_x

  function automatic logic [20:0] df_x(input logic [4:0] k);
    case (k)
      5'h00: return {1'b1, `OCF_F19440};
      5'h01: return {1'b1, `OCF_F38880};
      5'h02: return {1'b1, `OCF_F77760};
      5'h03: return {1'b1, `OCF_F155520};
      5'h04: return {1'b1, `OCF_F311040};
      5'h05: return {1'b1, `OCF_F622080};
      5'h06: return {1'b1, `OCF_F6480};
      5'h07: return {1'b1, `OCF_F51840};
      5'h09: return {1'b1, `OCF_F125000};
      5'h0A: return {1'b1, `OCF_F62500};
      5'h0D: return {1'b1, `OCF_F50000};
      5'h0E: return {1'b1, `OCF_F25000};
      5'h0F: return {1'b1, `OCF_F12500};
      5'h13: return {1'b1, `OCF_F156250};
      5'h14: return {1'b1, `OCF_F312500};
      default: return 21'h000000;
    endcase
  endfunction : df_x

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {err_total, n_checks, cyc} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      bus(1'b0, ix[k], 8'h00, 4'hF);
      chk("reset value", rd, 33'h0);
    end
    chk("se after reset", {se_v, se_f}, 33'h0);
    chk("diff after reset", {df_v, df_f}, {1'b1, `OCF_F19440});
    chk("synth after reset", syn_f, 33'(`OCF_SYNTH_ZERO_HZ));
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, ix[k], 8'h5A ^ 8'(k), 4'hF);
      bus(1'b0, ix[k], 8'h00, 4'hF);
      chk("readback", {e, rd}, {25'h0, 8'h5A ^ 8'(k)});
      bus(1'b1, ix[k], 8'h00, 4'hF);
    end
    bus(1'b1, `OCF_IDX_FP_RATE, 8'h05, 4'hE);
    bus(1'b0, `OCF_IDX_FP_RATE, 8'h00, 4'hF);
    chk("masked write", rd, 33'h0);
    bus(1'b1, 8'h37, 8'hFF, 4'hF);
    bus(1'b0, 8'h37, 8'h00, 4'hF);
    chk("unmapped", {e, rd}, {1'b1, 32'h0});
    $display("test registers done");
    for (int f = 0; f < 8; f++) begin
      wr(`OCF_IDX_FAMILY, 8'(f));
      for (int c = 0; c < 16; c++) begin
        wr(`OCF_IDX_SE_RATE, 8'(c));
        wr(`OCF_IDX_DIFF_RATE, 8'(c));
        chk("se rate", {se_v, se_f},
          se_x({f[0] & f[1], 4'(c)}));
        chk("diff rate", {df_v, df_f},
          df_x({f[0] ? (f[2] ? 2'd1 : 2'd2) : 2'd0, 3'(c)}));
      end
    end
    wr(`OCF_IDX_FAMILY, 8'h00);
    $display("test rate decode done");
    for (int k = 0; k < 5; k++) begin
      wr(`OCF_IDX_MULT_LO, nt[k][7:0]);
      wr(`OCF_IDX_MULT_HI, nt[k][15:8]);
      chk("synth", {ovr, syn_f}, {nt[k] > 16'h30D4, (nt[k] == 16'h0) ?
        32'(`OCF_SYNTH_ZERO_HZ) : 32'(nt[k]) * 32'h1F40});
    end
    $display("test synthesizer done");
    for (int s = 1; s >= 0; s--) begin
      wr(`OCF_IDX_SYNTH_EN, 8'(s));
      repeat (15) begin
        @(posedge pclk);
        a = tx_t;
        b = rx_t;
        @(negedge pclk);
        chk("pll ref", apll_t, a);
        chk("synth ref", syn_t, s ? b : a);
      end
    end
    $display("test reference select done");
    for (int k = 0; k < 9; k++) begin
      wr(`OCF_IDX_FP_RATE, 8'(k));
      wait_start();
      wait_start();
      p = 0;
      do begin
        @(negedge pclk);
        p++;
      end while (fst !== 1'b1 && p < 5000);
      chk("frame period", p, tk[k] * (BW / 2));
    end
    $display("test frame rate done");
    wr(`OCF_IDX_FP_RATE, 8'h05);
    for (int k = 0; k < 9; k++) begin
      wr(`OCF_IDX_MULT_LO, nv[k][7:0]);
      wr(`OCF_IDX_MULT_HI, nv[k][15:8]);
      wr(`OCF_IDX_FP_SHAPE, shp[k]);
      wait_start();
      wait_start();
      p = 0;
      w = 0;
      while ((fpo ^ shp[k][5]) !== 1'b1 && p < 200) begin
        @(negedge pclk);
        p++;
      end
      // Falling alignment adds half of a 2 MHz period, 25 cycles.
      chk("pulse delay", p, shp[k][4] ? 26 : 1);
      while ((fpo ^ shp[k][5]) === 1'b1 && w < 300) begin
        @(negedge pclk);
        w++;
      end
      chk("pulse width", w, wexp[k]);
    end
    $display("test frame shape done");
    report_and_stop();
  end
endmodule : ocf_top_tb
